/* verilog/gpio_regs_pkg.sv */
package gpio_regs_pkg;

	// ****************************************
	// widths
	// ****************************************
	localparam int PORT_W = 8;
	localparam int OFS_W  = 3;

	// ****************************************
	// bank zero offsets
	// ****************************************
	localparam logic [2:0] OFS_PORT_A_VALUE      = 3'h0;
	localparam logic [2:0] OFS_PORT_A_DIR        = 3'h1;
	localparam logic [2:0] OFS_PORT_A_DRIVE_TYPE = 3'h2;
	localparam logic [2:0] OFS_PORT_A_PULLUP_EN  = 3'h3;
	localparam logic [2:0] OFS_PORT_B_VALUE      = 3'h4;
	localparam logic [2:0] OFS_PORT_B_DIR        = 3'h5;
	localparam logic [2:0] OFS_PORT_B_DRIVE_TYPE = 3'h6;
	localparam logic [2:0] OFS_PORT_B_PULLUP_EN  = 3'h7;

	// ****************************************
	// bank one offsets
	// ****************************************
	localparam logic [2:0] OFS_PORT_A_CONFIG_FREEZE = 3'h0;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] RST_VALUE      = 8'hFF;
	localparam logic [7:0] RST_DIR        = 8'h00;
	localparam logic [7:0] RST_DRIVE_TYPE = 8'h00;
	localparam logic [7:0] RST_PULLUP_EN  = 8'hFF;
	localparam logic [7:0] RST_FREEZE     = 8'h00;

	// ****************************************
	// freeze field: bits 7-4 only
	// ****************************************
	localparam logic [7:0] FREEZE_MASK = 8'hF0;

	// ****************************************
	// bank select and port index
	// ****************************************
	typedef enum logic {BANK_ZERO, BANK_ONE} bank_t;
	localparam int PORT_A = 0;
	localparam int PORT_B = 1;

endpackage

/* verilog/gpio_pin_drive.sv */
module gpio_pin_drive
	import gpio_regs_pkg::*;
(
	input  wire logic              clock_i,
	input  wire logic              arst_n_i,
	input  wire logic [PORT_W-1:0] pin_i,
	input  wire logic [PORT_W-1:0] latch_i,
	input  wire logic [PORT_W-1:0] dir_i,
	input  wire logic [PORT_W-1:0] drive_type_i,
	input  wire logic [PORT_W-1:0] pullup_en_i,
	output logic      [PORT_W-1:0] pin_level_o,
	output logic      [PORT_W-1:0] pin_o,
	output logic      [PORT_W-1:0] pin_oe_o,
	output logic      [PORT_W-1:0] pullup_o
);

	logic [PORT_W-1:0] sync1_reg;
	logic [PORT_W-1:0] sync2_reg;
	logic [PORT_W-1:0] out_reg;
	logic [PORT_W-1:0] out_next;
	logic [PORT_W-1:0] oe_reg;
	logic [PORT_W-1:0] oe_next;
	logic [PORT_W-1:0] pull_reg;
	logic [PORT_W-1:0] pull_next;

	// ****************************************
	// drive decode per pin
	// ****************************************
	always_comb
	begin
		for (int i = 0; i < PORT_W; i++)
		begin
			// push-pull drives both levels, open-drain only low
			// level stays low while the pin is an input
			out_next[i] = dir_i[i] & drive_type_i[i]
				& latch_i[i];
			oe_next[i]  = dir_i[i]
				& (drive_type_i[i] | ~latch_i[i]);
		end
		pull_next = pullup_en_i;
	end

	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			out_reg   <= '0;
			oe_reg    <= '0;
			pull_reg  <= RST_PULLUP_EN;
		end
		else
		begin
			sync1_reg <= pin_i;
			sync2_reg <= sync1_reg;
			out_reg   <= out_next;
			oe_reg    <= oe_next;
			pull_reg  <= pull_next;
		end
	end

	assign pin_level_o = sync2_reg;
	assign pin_o       = out_reg;
	assign pin_oe_o    = oe_reg;
	assign pullup_o    = pull_reg;

endmodule

/* verilog/banked_gpio_port_registers.sv */
module banked_gpio_port_registers
	import gpio_regs_pkg::*;
(
	input  wire logic              clock_i,
	input  wire logic              arst_n_i,
	input  wire logic              bank_sel_i,
	input  wire logic [OFS_W-1:0]  reg_addr_i,
	input  wire logic              reg_wr_i,
	input  wire logic              reg_rd_i,
	input  wire logic [PORT_W-1:0] reg_wdata_i,
	output logic      [PORT_W-1:0] reg_rdata_o,
	input  wire logic [PORT_W-1:0] port_a_pin_i,
	output logic      [PORT_W-1:0] port_a_pin_o,
	output logic      [PORT_W-1:0] port_a_pin_oe_o,
	output logic      [PORT_W-1:0] port_a_pullup_o,
	input  wire logic [PORT_W-1:0] port_b_pin_i,
	output logic      [PORT_W-1:0] port_b_pin_o,
	output logic      [PORT_W-1:0] port_b_pin_oe_o,
	output logic      [PORT_W-1:0] port_b_pullup_o
);

	// ****************************************
	// state
	// ****************************************
	logic [PORT_W-1:0] value_reg      [2];
	logic [PORT_W-1:0] value_next     [2];
	logic [PORT_W-1:0] dir_reg        [2];
	logic [PORT_W-1:0] dir_next       [2];
	logic [PORT_W-1:0] drive_type_reg [2];
	logic [PORT_W-1:0] drive_type_next[2];
	logic [PORT_W-1:0] pullup_en_reg  [2];
	logic [PORT_W-1:0] pullup_en_next [2];
	logic [PORT_W-1:0] freeze_reg;
	logic [PORT_W-1:0] freeze_next;
	logic [PORT_W-1:0] rdata_reg;
	logic [PORT_W-1:0] rdata_next;
	logic [PORT_W-1:0] pin_level      [2];
	logic [PORT_W-1:0] pin_out        [2];
	logic [PORT_W-1:0] pin_oe         [2];
	logic [PORT_W-1:0] pullup_out     [2];
	bank_t             bank;

	assign bank = bank_t'(bank_sel_i);

	// merge new bits into old where the mask allows change
	function automatic logic [PORT_W-1:0] merge(
		input logic [PORT_W-1:0] old_v,
		input logic [PORT_W-1:0] new_v,
		input logic [PORT_W-1:0] keep
	);
		merge = (old_v & keep) | (new_v & ~keep);
	endfunction

	// read-back of a value register
	function automatic logic [PORT_W-1:0] value_view(
		input logic [PORT_W-1:0] latch,
		input logic [PORT_W-1:0] dir,
		input logic [PORT_W-1:0] level
	);
		value_view = (latch & dir) | (level & ~dir);
	endfunction

	// ****************************************
	// register writes
	// ****************************************
	always_comb
	begin
		logic [PORT_W-1:0] cfg_keep;
		logic [PORT_W-1:0] val_keep;
		cfg_keep = freeze_reg & FREEZE_MASK;
		val_keep = cfg_keep & dir_reg[PORT_A];
		for (int p = 0; p < 2; p++)
		begin
			value_next[p]      = value_reg[p];
			dir_next[p]        = dir_reg[p];
			drive_type_next[p] = drive_type_reg[p];
			pullup_en_next[p]  = pullup_en_reg[p];
		end
		freeze_next = freeze_reg;
		if (reg_wr_i && bank == BANK_ONE)
		begin
			if (reg_addr_i == OFS_PORT_A_CONFIG_FREEZE)
				// sticky set, zeros and low bits ignored
				freeze_next = freeze_reg
					| (reg_wdata_i & FREEZE_MASK);
		end
		else if (reg_wr_i)
		begin
			if (reg_addr_i == OFS_PORT_A_VALUE)
				value_next[PORT_A] = merge(value_reg[PORT_A],
					reg_wdata_i, val_keep);
			else if (reg_addr_i == OFS_PORT_A_DIR)
				dir_next[PORT_A] = merge(dir_reg[PORT_A],
					reg_wdata_i, cfg_keep);
			else if (reg_addr_i == OFS_PORT_A_DRIVE_TYPE)
				drive_type_next[PORT_A] = merge(drive_type_reg[PORT_A],
					reg_wdata_i, cfg_keep);
			else if (reg_addr_i == OFS_PORT_A_PULLUP_EN)
				pullup_en_next[PORT_A] = merge(pullup_en_reg[PORT_A],
					reg_wdata_i, cfg_keep);
			else if (reg_addr_i == OFS_PORT_B_VALUE)
				value_next[PORT_B] = reg_wdata_i;
			else if (reg_addr_i == OFS_PORT_B_DIR)
				dir_next[PORT_B] = reg_wdata_i;
			else if (reg_addr_i == OFS_PORT_B_DRIVE_TYPE)
				drive_type_next[PORT_B] = reg_wdata_i;
			else
				pullup_en_next[PORT_B] = reg_wdata_i;
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			for (int p = 0; p < 2; p++)
			begin
				value_reg[p]      <= RST_VALUE;
				dir_reg[p]        <= RST_DIR;
				drive_type_reg[p] <= RST_DRIVE_TYPE;
				pullup_en_reg[p]  <= RST_PULLUP_EN;
			end
			freeze_reg <= RST_FREEZE;
		end
		else
		begin
			for (int p = 0; p < 2; p++)
			begin
				value_reg[p]      <= value_next[p];
				dir_reg[p]        <= dir_next[p];
				drive_type_reg[p] <= drive_type_next[p];
				pullup_en_reg[p]  <= pullup_en_next[p];
			end
			freeze_reg <= freeze_next;
		end
	end

	// ****************************************
	// register reads
	// ****************************************
	always_comb
	begin
		rdata_next = rdata_reg;
		if (reg_rd_i && bank == BANK_ONE)
		begin
			if (reg_addr_i == OFS_PORT_A_CONFIG_FREEZE)
				rdata_next = freeze_reg & FREEZE_MASK;
			else
				rdata_next = '0;
		end
		else if (reg_rd_i)
		begin
			if (reg_addr_i == OFS_PORT_A_VALUE)
				rdata_next = value_view(value_reg[PORT_A],
					dir_reg[PORT_A], pin_level[PORT_A]);
			else if (reg_addr_i == OFS_PORT_A_DIR)
				rdata_next = dir_reg[PORT_A];
			else if (reg_addr_i == OFS_PORT_A_DRIVE_TYPE)
				rdata_next = drive_type_reg[PORT_A];
			else if (reg_addr_i == OFS_PORT_A_PULLUP_EN)
				rdata_next = pullup_en_reg[PORT_A];
			else if (reg_addr_i == OFS_PORT_B_VALUE)
				rdata_next = value_view(value_reg[PORT_B],
					dir_reg[PORT_B], pin_level[PORT_B]);
			else if (reg_addr_i == OFS_PORT_B_DIR)
				rdata_next = dir_reg[PORT_B];
			else if (reg_addr_i == OFS_PORT_B_DRIVE_TYPE)
				rdata_next = drive_type_reg[PORT_B];
			else
				rdata_next = pullup_en_reg[PORT_B];
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			rdata_reg <= '0;
		else
			rdata_reg <= rdata_next;
	end

	assign reg_rdata_o = rdata_reg;

	// ****************************************
	// pin drivers
	// ****************************************
	logic [PORT_W-1:0] pin_in [2];
	assign pin_in[PORT_A] = port_a_pin_i;
	assign pin_in[PORT_B] = port_b_pin_i;

	generate
		for (genvar g = 0; g < 2; g++)
		begin : g_port
			gpio_pin_drive u_drive (
				.clock_i      (clock_i),
				.arst_n_i     (arst_n_i),
				.pin_i        (pin_in[g]),
				.latch_i      (value_reg[g]),
				.dir_i        (dir_reg[g]),
				.drive_type_i (drive_type_reg[g]),
				.pullup_en_i  (pullup_en_reg[g]),
				.pin_level_o  (pin_level[g]),
				.pin_o        (pin_out[g]),
				.pin_oe_o     (pin_oe[g]),
				.pullup_o     (pullup_out[g])
			);
		end
	endgenerate

	assign port_a_pin_o    = pin_out[PORT_A];
	assign port_a_pin_oe_o = pin_oe[PORT_A];
	assign port_a_pullup_o = pullup_out[PORT_A];
	assign port_b_pin_o    = pin_out[PORT_B];
	assign port_b_pin_oe_o = pin_oe[PORT_B];
	assign port_b_pullup_o = pullup_out[PORT_B];

endmodule

/* test/board_pins.sv */
module board_pins
(
	input  wire logic [7:0] pin_o_i,
	input  wire logic [7:0] oe_i,
	input  wire logic [7:0] pullup_i,
	input  wire logic [7:0] ext_i,
	output logic      [7:0] level_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// driven bit wins, else pull-up or board level
	assign level_o = (oe_i & pin_o_i)
		| (~oe_i & (pullup_i | ext_i));
endmodule

/* test/gpio_regs_properties.sv */
module gpio_regs_checker
	import gpio_regs_pkg::*;
(
	input wire logic              clock_i,
	input wire logic              arst_n_i,
	input wire logic              bank_sel_i,
	input wire logic [OFS_W-1:0]  reg_addr_i,
	input wire logic              reg_wr_i,
	input wire logic              reg_rd_i,
	input wire logic [PORT_W-1:0] reg_wdata_i,
	input wire logic [PORT_W-1:0] reg_rdata_o,
	input wire logic [PORT_W-1:0] port_a_pin_o,
	input wire logic [PORT_W-1:0] port_a_pin_oe_o,
	input wire logic [PORT_W-1:0] port_a_pullup_o,
	input wire logic [PORT_W-1:0] port_b_pin_o,
	input wire logic [PORT_W-1:0] port_b_pin_oe_o,
	input wire logic [PORT_W-1:0] port_b_pullup_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!arst_n_i);
	AST_RD_HOLD: assert property (
		!reg_rd_i |=> $stable(reg_rdata_o))
		else $error("read data moved without a read");
	AST_FRZ_LOW: assert property (
		reg_rd_i && bank_sel_i && reg_addr_i == 3'h0
		|=> reg_rdata_o[3:0] == 4'h0)
		else $error("freeze low bits not zero");
	AST_BANK1_RSVD: assert property (
		reg_rd_i && bank_sel_i && reg_addr_i != 3'h0
		|=> reg_rdata_o == 8'h00)
		else $error("bank one hole not zero");
	AST_PU_B_WR: assert property (
		reg_wr_i && !bank_sel_i && reg_addr_i == 3'h7
		|-> ##2 port_b_pullup_o == $past(reg_wdata_i, 2))
		else $error("port b pull-up not written");
	AST_PU_B_RD: assert property (
		reg_rd_i && !bank_sel_i && reg_addr_i == 3'h7
		|=> reg_rdata_o == port_b_pullup_o)
		else $error("port b pull-up read");
	AST_PU_A_CHG: assert property (
		$changed(port_a_pullup_o)
		|-> $past(reg_wr_i, 2) && $past(reg_addr_i, 2) == 3'h3)
		else $error("port a pull-up moved without write");
	AST_OD_A: assert property (
		(port_a_pin_o & ~port_a_pin_oe_o) == 8'h00)
		else $error("port a drives high while released");
	AST_OD_B: assert property (
		(port_b_pin_o & ~port_b_pin_oe_o) == 8'h00)
		else $error("port b drives high while released");
	AST_OE_B_CHG: assert property (
		$changed(port_b_pin_oe_o) |-> $past(reg_wr_i, 2))
		else $error("port b enable moved without write");
	cover property (reg_wr_i && bank_sel_i && reg_addr_i == 3'h0);
	cover property (reg_rd_i && !bank_sel_i && reg_addr_i == 3'h7);
	cover property ($rose(|port_b_pin_oe_o));
endmodule

bind banked_gpio_port_registers gpio_regs_checker chk (.clock_i, .arst_n_i,
	.bank_sel_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o,
	.port_a_pin_o, .port_a_pin_oe_o, .port_a_pullup_o, .port_b_pin_o,
	.port_b_pin_oe_o, .port_b_pullup_o);

/* test/banked_gpio_port_registers_tb.sv */
module banked_gpio_port_registers_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clock_i, arst_n_i, bank_sel_i, reg_wr_i, reg_rd_i;
	logic [2:0] reg_addr_i;
	logic [7:0] reg_wdata_i, reg_rdata_o, ext_a, ext_b;
	logic [7:0] a_in, a_out, a_oe, a_pu, b_in, b_out, b_oe, b_pu;
	logic [7:0] rst_tab [8] = '{8'hFF, 8'h00, 8'h00, 8'hFF,
		8'hFF, 8'h00, 8'h00, 8'hFF};
	int         err_count, checks;
	banked_gpio_port_registers dut (.clock_i(clock_i), .arst_n_i(arst_n_i),
		.bank_sel_i(bank_sel_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
		.reg_rdata_o(reg_rdata_o), .port_a_pin_i(a_in), .port_a_pin_o(a_out),
		.port_a_pin_oe_o(a_oe), .port_a_pullup_o(a_pu), .port_b_pin_i(b_in),
		.port_b_pin_o(b_out), .port_b_pin_oe_o(b_oe), .port_b_pullup_o(b_pu));
	board_pins pa (.pin_o_i(a_out), .oe_i(a_oe), .pullup_i(a_pu),
		.ext_i(ext_a), .level_o(a_in));
	board_pins pb (.pin_o_i(b_out), .oe_i(b_oe), .pullup_i(b_pu),
		.ext_i(ext_b), .level_o(b_in));
	// ****************************************
	// bus cycles and comparison
	// ****************************************
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wr(input logic b, input logic [2:0] a, input logic [7:0] d);
		@(negedge clock_i);
		{bank_sel_i, reg_addr_i, reg_wdata_i, reg_wr_i} = {b, a, d, 1'b1};
		@(negedge clock_i);
		reg_wr_i = 1'b0;
	endtask
	task rd(input logic b, input logic [2:0] a, input logic [7:0] e);
		@(negedge clock_i);
		{bank_sel_i, reg_addr_i, reg_rd_i} = {b, a, 1'b1};
		@(negedge clock_i);
		reg_rd_i = 1'b0;
		@(negedge clock_i);
		chk(reg_rdata_o, e);
	endtask
	task settle;
		repeat (4) @(negedge clock_i);
	endtask
	task t_reset;
		for (int i = 0; i < 8; i++)
			rd(1'b0, i[2:0], rst_tab[i]);
		rd(1'b1, 3'h0, 8'h00);
		chk(a_pu & b_pu, 8'hFF);
		chk(a_oe | b_oe, 8'h00);
		$display("test reset done");
	endtask
	task t_port_b;
		ext_b = 8'h3C;
		wr(1'b0, 3'h7, 8'h00);
		settle;
		rd(1'b0, 3'h4, 8'h3C);
		wr(1'b0, 3'h4, 8'h5A);
		settle;
		chk(b_oe, 8'h00);
		wr(1'b0, 3'h6, 8'hFF);
		wr(1'b0, 3'h5, 8'hFF);
		settle;
		chk(b_out, 8'h5A);
		chk(b_oe, 8'hFF);
		rd(1'b0, 3'h4, 8'h5A);
		wr(1'b0, 3'h6, 8'h00);
		settle;
		chk(b_out, 8'h00);
		chk(b_oe, 8'hA5);
		wr(1'b0, 3'h7, 8'h0F);
		settle;
		chk(b_pu, 8'h0F);
		wr(1'b1, 3'h7, 8'h12);
		rd(1'b1, 3'h7, 8'h00);
		rd(1'b0, 3'h7, 8'h0F);
		$display("test port b done");
	endtask
	task t_lock;
		ext_a = 8'h00;
		wr(1'b0, 3'h3, 8'h00);
		wr(1'b0, 3'h1, 8'hF0);
		wr(1'b1, 3'h0, 8'h30);
		rd(1'b1, 3'h0, 8'h30);
		wr(1'b1, 3'h0, 8'h0F);
		rd(1'b1, 3'h0, 8'h30);
		wr(1'b0, 3'h1, 8'h00);
		rd(1'b0, 3'h1, 8'h30);
		wr(1'b0, 3'h3, 8'hFF);
		rd(1'b0, 3'h3, 8'hCF);
		wr(1'b0, 3'h2, 8'hFF);
		rd(1'b0, 3'h2, 8'hCF);
		wr(1'b0, 3'h0, 8'h00);
		settle;
		rd(1'b0, 3'h0, 8'hFF);
		chk(a_oe, 8'h00);
		chk(a_out, 8'h00);
		chk(a_pu, 8'hCF);
		@(negedge clock_i);
		arst_n_i = 1'b0;
		repeat (2) @(negedge clock_i);
		arst_n_i = 1'b1;
		rd(1'b1, 3'h0, 8'h00);
		chk(a_pu, 8'hFF);
		$display("test lock done");
	endtask
	task report_and_stop;
		$display("checks=%0d mismatches=%0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end
	initial
	begin
		#50us;
		err_count++;
		report_and_stop;
	end
	initial
	begin
		{arst_n_i, bank_sel_i, reg_wr_i, reg_rd_i} = 4'h0;
		{reg_addr_i, reg_wdata_i, ext_a, ext_b} = 27'h0;
		repeat (20) @(negedge clock_i);
		arst_n_i = 1'b1;
		// pin levels need two edges through the synchroniser
		settle;
		t_reset;
		t_port_b;
		t_lock;
		report_and_stop;
	end
endmodule
